// >>> shared/bit_test_skip_decode_defines.svh
`ifndef BIT_TEST_SKIP_DECODE_DEFINES_SVH
`define BIT_TEST_SKIP_DECODE_DEFINES_SVH

// ----------------------------------------------------------------------
// Opcode fields (upper nibble of the instruction word)
// ----------------------------------------------------------------------
`define OPC_SKIP_CLEAR   4'hB
`define OPC_SKIP_SET     4'hA
`define OPC_SET_BIT      4'h8

// ----------------------------------------------------------------------
// Instruction word layout
// ----------------------------------------------------------------------
`define IW_OPC_MSB       15
`define IW_OPC_LSB       12
`define IW_BIT_MSB       11
`define IW_BIT_LSB       9
`define IW_BANK_POS      8
`define IW_FILE_MSB      7
`define IW_FILE_LSB      0

// ----------------------------------------------------------------------
// Fixed words and reset values
// ----------------------------------------------------------------------
`define NOP_WORD         16'h0000
`define ADDR_RST         12'h000
`define DATA_RST         8'h00

// ----------------------------------------------------------------------
// Access bank layout
// ----------------------------------------------------------------------
`define ACC_LOW_BANK     4'h0
`define ACC_HIGH_BANK    4'hF
`define ACC_SPLIT        8'h60
`define INDEXED_LIMIT    8'h5F

`endif

// >>> shared/bit_test_skip_decode_pkg.sv
package bit_test_skip_decode_pkg;

  // Four phases of one instruction cycle, one-hot
  typedef enum logic [3:0] {
    Q1 = 4'h1,
    Q2 = 4'h2,
    Q3 = 4'h4,
    Q4 = 4'h8
  } q_phase_t;

  // Instruction word fields
  typedef struct packed {
    logic [3:0] opc;
    logic [2:0] bit_sel;
    logic       bank_sel;
    logic [7:0] file;
  } instr_t;

  // Core state reported outward
  typedef struct packed {
    logic [3:0]  phase;
    logic        nop_cycle;
    logic        skip;
    logic        tested_bit;
    logic [11:0] file_addr;
  } core_status_t;

endpackage

// >>> hdl/file_ram.sv
`timescale 1ns/1ps
`default_nettype none

module file_ram
(
  input  wire logic        mclk,
  input  wire logic        rd_en,
  input  wire logic        wr_en,
  input  wire logic [11:0] addr,
  input  wire logic [7:0]  wdata,
  output var  logic [7:0]  rdata_r
);

  // ----------------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------------
  logic [7:0] mem [0:4095] = '{default: 8'h00};   // General purpose ram words, zero at start

  // Registered read, plain write
  always_ff @(posedge mclk)
  begin
    if (wr_en)
    begin
      mem[addr] <= wdata;
    end
    if (rd_en)
    begin
      rdata_r <= mem[addr];
    end
  end

endmodule

`default_nettype wire

// >>> hdl/bit_test_skip_decode.sv
// Operation
// [RULE1] Skip-when-clear skips next when bit zero
// [RULE2] Taken skip discards prefetch, runs no-op
// [RULE3] Taken skip makes instruction two cycles
// [RULE4] Bank bit 0 access bank, 1 bank_select_reg
// [RULE5] Extended set, bank 0, f<=5Fh: indexed
// [RULE6] Skip-when-set skips next when bit one
`timescale 1ns/1ps
`default_nettype none
`include "bit_test_skip_decode_defines.svh"

module bit_test_skip_decode
(
  input  wire logic                                mclk,
  input  wire logic                                srst,
  input  wire logic [15:0]                         fetch_word,
  input  wire logic [3:0]                          bank_select_reg,
  input  wire logic [11:0]                         index_base,
  input  wire logic                                ext_set_en,
  output var  bit_test_skip_decode_pkg::core_status_t status
);
  import bit_test_skip_decode_pkg::*;

  // ----------------------------------------------------------------------
  // Functions
  // ----------------------------------------------------------------------
  // Split an instruction word into fields
  function automatic instr_t unpack_word(input logic [15:0] w);
    instr_t i;
    i.opc      = w[`IW_OPC_MSB:`IW_OPC_LSB];
    i.bit_sel  = w[`IW_BIT_MSB:`IW_BIT_LSB];
    i.bank_sel = w[`IW_BANK_POS];
    i.file     = w[`IW_FILE_MSB:`IW_FILE_LSB];
    return i;
  endfunction

  // Effective file address of the operand
  function automatic logic [11:0] eff_addr(input instr_t i, input logic [3:0] bank,
                                           input logic [11:0] base, input logic ext);
    logic [11:0] a;
    if (i.bank_sel)
    begin
      a = {bank, i.file};                                    // RULE4
    end
    else if (ext && (i.file <= `INDEXED_LIMIT))
    begin
      a = 12'(base + {4'h0, i.file});                        // RULE5
    end
    else if (i.file < `ACC_SPLIT)
    begin
      a = {`ACC_LOW_BANK, i.file};                           // RULE4
    end
    else
    begin
      a = {`ACC_HIGH_BANK, i.file};                          // RULE4
    end
    return a;
  endfunction

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  q_phase_t    q_r, q_nxt;                 // Current phase
  instr_t      ir_r, ir_nxt;               // Executing instruction
  logic        nop_r, nop_nxt;             // Cycle is a forced no-op
  logic        skip_r, skip_nxt;           // Skip decided in Q3
  logic        tbit_r, tbit_nxt;           // Tested bit value
  logic [11:0] addr_r, addr_nxt;           // Operand address
  logic        wr_r, wr_nxt;               // Write strobe for set-bit
  logic [7:0]  wdata_r, wdata_nxt;         // Write data for set-bit
  logic [7:0]  rdata_r;                    // Operand, valid in Q3
  logic        rd_en;                      // Read request in Q2
  logic        is_clr, is_set, is_bset;    // Opcode decode

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  // Opcode class of the latched instruction
  always_comb
  begin
    is_clr  = !nop_r && (ir_r.opc == `OPC_SKIP_CLEAR);
    is_set  = !nop_r && (ir_r.opc == `OPC_SKIP_SET);
    is_bset = !nop_r && (ir_r.opc == `OPC_SET_BIT);
    rd_en   = (q_r == Q2);                 // Address settled since Q1
  end

  // ----------------------------------------------------------------------
  // Phase and pipeline next state
  // ----------------------------------------------------------------------
  always_comb
  begin
    q_nxt     = q_r;
    ir_nxt    = ir_r;
    nop_nxt   = nop_r;
    skip_nxt  = skip_r;
    tbit_nxt  = tbit_r;
    addr_nxt  = addr_r;
    wr_nxt    = 1'b0;
    wdata_nxt = wdata_r;
    unique case (q_r)
      Q1:
      begin
        // Decode, form operand address
        q_nxt    = Q2;
        skip_nxt = 1'b0;
        addr_nxt = eff_addr(ir_r, bank_select_reg, index_base, ext_set_en);
      end
      Q2:
      begin
        // Ram reads the operand at this edge
        q_nxt = Q3;
      end
      Q3:
      begin
        // Process data: test or set the selected bit
        q_nxt     = Q4;
        tbit_nxt  = rdata_r[ir_r.bit_sel];
        skip_nxt  = (is_clr && !rdata_r[ir_r.bit_sel])      // RULE1
                  || (is_set && rdata_r[ir_r.bit_sel]);     // RULE6
        wdata_nxt = rdata_r | (8'h01 << ir_r.bit_sel);
        wr_nxt    = is_bset;
      end
      Q4:
      begin
        // Take the prefetched word, or drop it on a skip
        q_nxt = Q1;
        if (skip_r)
        begin
          ir_nxt  = unpack_word(`NOP_WORD);                 // RULE2
          nop_nxt = 1'b1;                                   // RULE3
        end
        else
        begin
          ir_nxt  = unpack_word(fetch_word);
          nop_nxt = 1'b0;
        end
      end
      default:
      begin
        // Illegal phase code recovers to Q1
        q_nxt = Q1;
      end
    endcase
  end

  // Register the pipeline
  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      q_r     <= Q1;
      ir_r    <= unpack_word(`NOP_WORD);
      nop_r   <= 1'b1;
      skip_r  <= 1'b0;
      tbit_r  <= 1'b0;
      addr_r  <= `ADDR_RST;
      wr_r    <= 1'b0;
      wdata_r <= `DATA_RST;
    end
    else
    begin
      q_r     <= q_nxt;
      ir_r    <= ir_nxt;
      nop_r   <= nop_nxt;
      skip_r  <= skip_nxt;
      tbit_r  <= tbit_nxt;
      addr_r  <= addr_nxt;
      wr_r    <= wr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // File register memory
  // ----------------------------------------------------------------------
  file_ram u_ram
  (
    .mclk    (mclk),
    .rd_en   (rd_en),
    .wr_en   (wr_r),
    .addr    (addr_r),
    .wdata   (wdata_r),
    .rdata_r (rdata_r)
  );

  // Status from flops only
  assign status = '{phase: q_r, nop_cycle: nop_r, skip: skip_r,
                    tested_bit: tbit_r, file_addr: addr_r};

  // ----------------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------------
  sequence s_clear_hit;
    (q_r == Q3) && is_clr && !rdata_r[ir_r.bit_sel];
  endsequence

  sequence s_set_hit;
    (q_r == Q3) && is_set && rdata_r[ir_r.bit_sel];
  endsequence

  sequence s_skip_end;
    (q_r == Q4) && skip_r;
  endsequence

  sequence s_nop_cycle;
    (nop_r && (ir_r == unpack_word(`NOP_WORD))) [*4];
  endsequence

  a_clear_skip: assert property (@(posedge mclk) disable iff (srst) // RULE1
    s_clear_hit |=> skip_r && (q_r == Q4))
    else $error("skip-when-clear did not skip on zero bit");

  a_set_skip: assert property (@(posedge mclk) disable iff (srst) // RULE6
    s_set_hit |=> skip_r && (q_r == Q4))
    else $error("skip-when-set did not skip on one bit");

  a_no_false_skip: assert property (@(posedge mclk) disable iff (srst) // RULE1
    ((q_r == Q3) && !((is_clr && !rdata_r[ir_r.bit_sel])
      || (is_set && rdata_r[ir_r.bit_sel]))) |=> !skip_r)
    else $error("skip raised without a matching bit test");

  a_discard_nop: assert property (@(posedge mclk) disable iff (srst) // RULE2
    s_skip_end |=> s_nop_cycle)
    else $error("prefetched word not replaced by no-op");

  a_two_cycles: assert property (@(posedge mclk) disable iff (srst) // RULE3
    s_skip_end ##1 s_nop_cycle |=> !nop_r && (q_r == Q1))
    else $error("skipping instruction not exactly two cycles");

  a_bank_reg: assert property (@(posedge mclk) disable iff (srst) // RULE4
    ((q_r == Q1) && ir_r.bank_sel) |=> addr_r == {$past(bank_select_reg), ir_r.file})
    else $error("bank bit one did not use bank_select_reg");

  a_access_bank: assert property (@(posedge mclk) disable iff (srst) // RULE4
    ((q_r == Q1) && !ir_r.bank_sel && !ext_set_en)
      |=> addr_r[7:0] == ir_r.file
      && addr_r[11:8] == (ir_r.file < `ACC_SPLIT ? `ACC_LOW_BANK : `ACC_HIGH_BANK))
    else $error("bank bit zero did not use access bank");

  a_indexed_mode: assert property (@(posedge mclk) disable iff (srst) // RULE5
    ((q_r == Q1) && !ir_r.bank_sel && ext_set_en && (ir_r.file <= `INDEXED_LIMIT))
      |=> addr_r == 12'($past(index_base) + {4'h0, ir_r.file}))
    else $error("indexed literal offset address wrong");

endmodule

`default_nettype wire

// >>> testbench/bit_test_skip_decode_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "bit_test_skip_decode_defines.svh"

module bit_test_skip_decode_tb_top;
  import bit_test_skip_decode_pkg::*;

  // ------------------------------------------------------------
  // Signals and model state
  // ------------------------------------------------------------
  logic         mclk;            // Core clock, 100 ns
  logic         srst;            // Synchronous reset
  logic [15:0]  fetch_word;      // Prefetched word
  logic [3:0]   bank_select_reg; // Bank register
  logic [11:0]  index_base;      // Indexed base pointer
  logic         ext_set_en;      // Extended set enable
  core_status_t status;          // Core status
  int           bad_count;       // Mismatches
  int           check_count;     // Comparisons
  int           cycles;          // Hang guard
  logic [7:0]   ram_model [4096]; // Model of ram contents

  bit_test_skip_decode bit_test_skip_decode_inst
  (
    .mclk            (mclk),
    .srst            (srst),
    .fetch_word      (fetch_word),
    .bank_select_reg (bank_select_reg),
    .index_base      (index_base),
    .ext_set_en      (ext_set_en),
    .status          (status)
  );

  // Clock
  always #50 mclk = ~mclk;

  // Cut a hang short
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      bad_count++;
      stop_test();
    end
  end

  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  // Verdict and end of run
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // One comparison
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Step to a phase at a falling edge, bounded
  task automatic wait_phase(input logic [3:0] q);
    int n;
    n = 0;
    @(negedge mclk);
    while (status.phase !== q && n < 8)
    begin
      @(negedge mclk);
      n++;
    end
    chk("phase", {8'h00, q}, {8'h00, status.phase});
  endtask

  // Model of the operand address
  function automatic int eff_addr(input logic [15:0] w);
    if (w[8])
      return {bank_select_reg, w[7:0]};
    if (ext_set_en && w[7:0] <= `INDEXED_LIMIT)
      return int'(index_base + {4'h0, w[7:0]});
    return (w[7:0] < `ACC_SPLIT) ? {`ACC_LOW_BANK, w[7:0]} : {`ACC_HIGH_BANK, w[7:0]};
  endfunction

  // Offer a word at Q4, follow its cycle and any forced no-op
  task automatic issue(input logic [15:0] w);
    int a;
    int b;
    int skip_exp;
    logic tst;
    a = eff_addr(w);
    b = w[11:9];
    tst = (w[15:12] == `OPC_SKIP_CLEAR) || (w[15:12] == `OPC_SKIP_SET);
    skip_exp = tst && (ram_model[a][b] == (w[15:12] == `OPC_SKIP_SET));
    fetch_word = w;
    wait_phase(Q2);
    if (tst || w[15:12] == `OPC_SET_BIT)
      chk("file_addr", a[11:0], status.file_addr);
    chk("nop_cycle", 12'h000, {11'h000, status.nop_cycle});
    wait_phase(Q4);
    if (tst)
      chk("tested_bit", {11'h000, ram_model[a][b]}, {11'h000, status.tested_bit});
    chk("skip", skip_exp[11:0], {11'h000, status.skip});
    if (w[15:12] == `OPC_SET_BIT)
      ram_model[a][b] = 1'b1;
    if (skip_exp != 0)
    begin
      // Decoy would skip if it were run after a taken skip-when-set
      fetch_word = {`OPC_SKIP_SET, w[11:0]};
      wait_phase(Q2);
      chk("nop_cycle", 12'h001, {11'h000, status.nop_cycle});
      wait_phase(Q4);
      chk("nop_cycle", 12'h001, {11'h000, status.nop_cycle});
      chk("skip", 12'h000, {11'h000, status.skip});
    end
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    logic [7:0] fsel [4];
    logic [7:0] f;
    logic [2:0] b;
    logic       a;
    logic [2:0] t;
    fsel = '{8'h5F, 8'h60, 8'h00, 8'hFF};
    // Ram starts at zero, so do the model words
    foreach (ram_model[k])
      ram_model[k] = 8'h00;
    mclk = 1'b0;
    srst = 1'b1;
    fetch_word = `NOP_WORD;
    bank_select_reg = 4'h0;
    index_base = 12'h000;
    ext_set_en = 1'b0;
    bad_count = 0;
    check_count = 0;
    cycles = 0;
    void'($urandom(32'hF95D));
    repeat (10) @(negedge mclk);
    // Reset values
    chk("phase", 12'h001, {8'h00, status.phase});
    chk("nop_cycle", 12'h001, {11'h000, status.nop_cycle});
    chk("file_addr", `ADDR_RST, status.file_addr);
    srst = 1'b0;
    wait_phase(Q4);
    // Address boundaries first, then random operands
    for (int i = 0; i < 40; i++)
    begin
      ext_set_en = (i < 8) ? i[0] : 1'($urandom_range(1, 0));
      f = (i < 8) ? fsel[i / 2] : 8'($urandom_range(255, 0));
      a = (i < 8) ? 1'b0 : 1'($urandom_range(1, 0));
      b = 3'($urandom_range(7, 0));
      bank_select_reg = 4'($urandom_range(15, 0));
      index_base = 12'($urandom_range(4095, 0));
      issue({`OPC_SET_BIT, b, a, f});
      // Test the bit just set, or another one that may still be clear
      t = i[1] ? b : 3'($urandom_range(7, 0));
      issue({i[0] ? `OPC_SKIP_SET : `OPC_SKIP_CLEAR, t, a, f});
      issue({4'h5, 12'($urandom)});
      $display("test %0d done", i);
    end
    stop_test();
  end

endmodule

`default_nettype wire
